/* iptr_pkg.sv */
package iptr_pkg;

	// Source space
	localparam int NUM_SRC      = 54;
	localparam int NUM_NIB      = 56;
	localparam int NUM_PRIO_REG = 14;
	localparam int NIB_PER_REG  = 4;
	localparam int NIB_W        = 4;
	localparam int PRIO_W       = 3;
	localparam int SRC_W        = 6;
	localparam int VEC_W        = 8;
	localparam int LVL_W        = 4;
	localparam int PC_W         = 24;
	localparam int NUM_WREG     = 16;
	localparam int NUM_TRAP     = 4;
	localparam int NUM_RCAUSE   = 6;

	// Vector numbering
	localparam logic [VEC_W-1:0] VEC_OFFSET = 8'h08;
	localparam logic [NUM_SRC-1:0] RESERVED_MASK = 54'h3F_F81E_1780_8010;
	localparam logic [PC_W-1:0] RESET_PC = 24'h00_0000;
	localparam logic [LVL_W-1:0] TRAP_LVL_BASE = 4'h8;

	// Trap slots; level is base plus slot plus three
	localparam int TRAP_MATH  = 0;
	localparam int TRAP_ADDR  = 1;
	localparam int TRAP_STACK = 2;
	localparam int TRAP_OSC   = 3;
	localparam logic [LVL_W-1:0] TRAP_SLOT_SKEW = 4'h3;

	// Reset cause bits
	localparam int RC_WDT     = 0;
	localparam int RC_UNINITW = 1;
	localparam int RC_ILLEGAL = 2;
	localparam int RC_LOCKOUT = 3;
	localparam int RC_EXT0    = 4;
	localparam int RC_EXT1    = 5;

	// Register byte offsets, 32-bit words
	localparam logic [7:0] OFS_PRIO_BASE = 8'h00;
	localparam logic [7:0] OFS_ENA_LO    = 8'h40;
	localparam logic [7:0] OFS_ENA_HI    = 8'h44;
	localparam logic [7:0] OFS_CTRL      = 8'h48;
	localparam logic [7:0] OFS_STATUS    = 8'h4C;
	localparam logic [7:0] OFS_RCAUSE    = 8'h50;

	// Control fields
	localparam int CTRL_OVF31_EN = 0;
	localparam int CTRL_OVF39_EN = 1;
	localparam int ENA_HI_W      = 22;

endpackage

/* iptr_resolver.sv */
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module iptr_resolver (
	input  wire  logic                              clk,
	input  wire  logic                              rst,
	// Avalon-MM slave
	input  wire  logic [7:0]                        address,
	input  wire  logic                              read,
	input  wire  logic                              write,
	input  wire  logic [31:0]                       writedata,
	output logic [31:0]                             readdata,
	output logic                                    waitrequest,
	// Peripheral request flags
	input  wire  logic [iptr_pkg::NUM_SRC-1:0]      irqPending,
	// Core state
	input  wire  logic [iptr_pkg::LVL_W-1:0]        cpuPriorityLevel,
	input  wire  logic                              instrDone,
	input  wire  logic                              trapAck,
	// Math trap sources
	input  wire  logic                              divByZero,
	input  wire  logic                              accOvf31,
	input  wire  logic                              guardBitsUnused,
	input  wire  logic                              accOvf39,
	input  wire  logic                              saturationOff,
	input  wire  logic                              shiftOverRange,
	// Other trap sources
	input  wire  logic                              badTrapVector,
	input  wire  logic                              addrFault,
	input  wire  logic                              stackFault,
	input  wire  logic                              oscFault,
	// Reset-causing conditions
	input  wire  logic                              watchdogTimeout,
	input  wire  logic                              opExecute,
	input  wire  logic                              opIllegal,
	input  wire  logic                              opFlushed,
	input  wire  logic [iptr_pkg::NUM_WREG-1:0]     wRegWrite,
	input  wire  logic                              wPtrUse,
	input  wire  logic [3:0]                        wPtrIndex,
	input  wire  logic [1:0]                        extResetErr,
	// Winning request to the core
	output logic                                    reqValid,
	output logic                                    reqIsTrap,
	output logic [iptr_pkg::VEC_W-1:0]              reqVector,
	output logic [iptr_pkg::LVL_W-1:0]              reqLevel,
	output logic                                    divAbort,
	output logic                                    coreResetReq,
	output logic [iptr_pkg::PC_W-1:0]               resetPc
);

	localparam int N  = iptr_pkg::NUM_SRC;
	localparam int PW = iptr_pkg::PRIO_W;
	localparam int NT = iptr_pkg::NUM_TRAP;

	// Winner search: highest priority, lowest number on a tie
	function automatic logic [9:0] pickWinner(
		input logic [N-1:0]    elig,
		input logic [N*PW-1:0] prios
	);
		logic [9:0] best;
		best = 10'h000;
		for (int i = N - 1; i >= 0; i--) begin
			if (elig[i] && prios[i*PW +: PW] >= best[8:6]) begin
				best = {1'b1, prios[i*PW +: PW], 6'(i)};
			end
		end
		return best;
	endfunction

	// Word decode shared by the read mux and write strobes
	function automatic logic isReg(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return addr == ofs;
	endfunction

	// Registers
	logic [PW-1:0]                  nib_q [iptr_pkg::NUM_NIB];
	logic [31:0]                    enaLo_q;
	logic [iptr_pkg::ENA_HI_W-1:0]  enaHi_q;
	logic [1:0]                     ctrl_q;
	logic [iptr_pkg::NUM_RCAUSE-1:0] rcause_q;
	logic [iptr_pkg::NUM_RCAUSE-1:0] rcause_d;
	logic [NT-1:0]                  trapPend_q;
	logic [NT-1:0]                  trapPend_d;
	logic [iptr_pkg::NUM_WREG-1:0]  wInit_q;
	logic                           waitReq_q;
	logic [31:0]                    rdData_q;
	logic                           reqValid_q;
	logic                           reqTrap_q;
	logic [iptr_pkg::VEC_W-1:0]     reqVec_q;
	logic [iptr_pkg::LVL_W-1:0]     reqLvl_q;
	logic                           divAbort_q;
	logic                           rstReq_q;
	logic [iptr_pkg::PC_W-1:0]      resetPc_q;

	// Bus decode
	wire                 busReq   = read | write;
	wire                 wrStrobe = write & ~waitReq_q;
	wire                 prioHit  = address[7:6] == 2'b00 &&
	                                address[5:2] < 4'(iptr_pkg::NUM_PRIO_REG) &&
	                                address[1:0] == 2'b00;
	wire [3:0]           prioIdx  = address[5:2];
	wire                 hitEnaLo = isReg(address, iptr_pkg::OFS_ENA_LO);
	wire                 hitEnaHi = isReg(address, iptr_pkg::OFS_ENA_HI);
	wire                 hitCtrl  = isReg(address, iptr_pkg::OFS_CTRL);
	wire                 hitStat  = isReg(address, iptr_pkg::OFS_STATUS);
	wire                 hitRc    = isReg(address, iptr_pkg::OFS_RCAUSE);

	// Nibble-packed view; bit 3 of every nibble reads zero
	wire [N*PW-1:0]      prioFlat;
	wire [N-1:0]         irqEnable = {enaHi_q, enaLo_q};
	wire [N-1:0]         eligible;
	wire [15:0]          prioRead;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gSrc
			assign prioFlat[g*PW +: PW] = nib_q[g];
			// Zero priority or reserved number never competes
			assign eligible[g] = irqPending[g] & irqEnable[g] &
			                     ~iptr_pkg::RESERVED_MASK[g] &
			                     (nib_q[g] != 3'h0);
		end
		for (g = 0; g < iptr_pkg::NIB_PER_REG; g++) begin : gRd
			assign prioRead[g*iptr_pkg::NIB_W +: iptr_pkg::NIB_W] =
				{1'b0, nib_q[prioIdx*4 + 4'(g)]};
		end
	endgenerate

	// Interrupt arbitration
	wire [9:0]           irqWin   = pickWinner(eligible, prioFlat);
	wire                 irqFound = irqWin[9];
	wire [PW-1:0]        irqPrio  = irqWin[8:6];
	wire [5:0]           irqSrc   = irqWin[5:0];
	wire                 irqBeats = irqFound &&
	                                {1'b0, irqPrio} > cpuPriorityLevel;

	// Math trap conditions
	wire ovf31Trap = ctrl_q[iptr_pkg::CTRL_OVF31_EN] &
	                 accOvf31 & guardBitsUnused;
	wire ovf39Trap = ctrl_q[iptr_pkg::CTRL_OVF39_EN] &
	                 accOvf39 & saturationOff;
	wire mathEvt   = divByZero | ovf31Trap | ovf39Trap | shiftOverRange;

	// Trap events by slot
	wire [NT-1:0] trapEvt;
	assign trapEvt[iptr_pkg::TRAP_MATH]  = mathEvt;
	assign trapEvt[iptr_pkg::TRAP_ADDR]  = addrFault | badTrapVector;
	assign trapEvt[iptr_pkg::TRAP_STACK] = stackFault;
	assign trapEvt[iptr_pkg::TRAP_OSC]   = oscFault;

	// Events in more than one trap slot in the same cycle are a lockout
	wire [2:0] trapCount = 3'(trapEvt[0]) + 3'(trapEvt[1]) +
	                       3'(trapEvt[2]) + 3'(trapEvt[3]);
	wire       lockout   = trapCount > 3'h1;

	// Highest pending trap slot
	wire       trapAny   = |trapPend_q;
	wire [1:0] trapSlot  = trapPend_q[3] ? 2'd3 :
	                       trapPend_q[2] ? 2'd2 :
	                       trapPend_q[1] ? 2'd1 : 2'd0;
	wire [iptr_pkg::LVL_W-1:0] trapLvl = iptr_pkg::TRAP_LVL_BASE +
	                       iptr_pkg::TRAP_SLOT_SKEW + 4'(trapSlot);
	// Trap above the running level nests; level 7 never masks it
	wire       trapBeats = trapAny && trapLvl > cpuPriorityLevel;
	// Only after the faulting instruction has finished
	wire       trapGo    = trapBeats & instrDone;

	// Reset-causing conditions
	wire uninitUse = wPtrUse & ~wInit_q[wPtrIndex];
	wire illegalEx = opExecute & opIllegal & ~opFlushed;
	wire [iptr_pkg::NUM_RCAUSE-1:0] rcEvt;
	assign rcEvt[iptr_pkg::RC_WDT]     = watchdogTimeout;
	assign rcEvt[iptr_pkg::RC_UNINITW] = uninitUse;
	assign rcEvt[iptr_pkg::RC_ILLEGAL] = illegalEx;
	assign rcEvt[iptr_pkg::RC_LOCKOUT] = lockout;
	assign rcEvt[iptr_pkg::RC_EXT0]    = extResetErr[0];
	assign rcEvt[iptr_pkg::RC_EXT1]    = extResetErr[1];
	wire anyReset = |rcEvt;

	// Sticky causes, write one to clear, a new event wins
	wire rcClr = wrStrobe & hitRc;
	assign rcause_d = (rcause_q &
	                   ~(rcClr ? writedata[iptr_pkg::NUM_RCAUSE-1:0] :
	                     6'h00)) | rcEvt;

	// Lockout drops the trap set; an ack clears the slot shown
	wire [NT-1:0] ackMask = (trapAck && trapAny) ? (4'h1 << trapSlot) : 4'h0;
	assign trapPend_d = (trapPend_q & ~ackMask) |
	                    (lockout ? 4'h0 : trapEvt);

	// Status read view
	wire [31:0] statusWord = {8'h00, reqVec_q, 3'h0, reqTrap_q,
	                          reqLvl_q, trapPend_q, 3'h0, reqValid_q};

	// Read mux, unmapped words read zero
	wire [31:0] rdMux =
		prioHit  ? {16'h0000, prioRead} :
		hitEnaLo ? enaLo_q :
		hitEnaHi ? {10'h000, enaHi_q} :
		hitCtrl  ? {30'h0000_0000, ctrl_q} :
		hitStat  ? statusWord :
		hitRc    ? {26'h000_0000, rcause_q} :
		32'h0000_0000;

	// Winner selection, trap ahead of any interrupt
	wire                       winValid = trapGo | irqBeats;
	wire                       winTrap  = trapGo;
	// A firing reset condition hides the whole winner, not just valid
	wire                       winShow  = winValid & ~anyReset;
	wire [iptr_pkg::VEC_W-1:0] winVec   = trapGo ? 8'(trapLvl) -
	                                      iptr_pkg::VEC_OFFSET :
	                                      8'(irqSrc) + iptr_pkg::VEC_OFFSET;
	wire [iptr_pkg::LVL_W-1:0] winLvl   = trapGo ? trapLvl :
	                                      {1'b0, irqPrio};

	// Bus handshake: one wait cycle, data latched with it
	always_ff @(posedge clk) begin
		if (rst) begin
			waitReq_q <= 1'b1;
			rdData_q  <= 32'h0000_0000;
		end else begin
			waitReq_q <= ~(busReq & waitReq_q);
			if (read && waitReq_q) begin
				rdData_q <= rdMux;
			end
		end
	end

	// Priority nibbles, writes ignore bit 3 of each nibble
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int k = 0; k < iptr_pkg::NUM_NIB; k++) begin
				nib_q[k] <= 3'h0;
			end
		end else if (wrStrobe && prioHit) begin
			for (int j = 0; j < iptr_pkg::NIB_PER_REG; j++) begin
				nib_q[prioIdx*4 + 4'(j)] <= writedata[j*4 +: PW];
			end
		end
	end

	// Enables and control
	always_ff @(posedge clk) begin
		if (rst) begin
			enaLo_q <= 32'h0000_0000;
			enaHi_q <= 22'h00_0000;
			ctrl_q  <= 2'h0;
		end else if (wrStrobe) begin
			if (hitEnaLo) enaLo_q <= writedata;
			if (hitEnaHi) enaHi_q <= writedata[iptr_pkg::ENA_HI_W-1:0];
			if (hitCtrl) ctrl_q <= writedata[1:0];
		end
	end

	// Trap pending and reset cause flags
	always_ff @(posedge clk) begin
		if (rst) begin
			trapPend_q <= 4'h0;
			rcause_q   <= 6'h00;
		end else begin
			trapPend_q <= trapPend_d;
			rcause_q   <= rcause_d;
		end
	end

	// Working registers written since reset
	always_ff @(posedge clk) begin
		if (rst) begin
			wInit_q <= 16'h0000;
		end else begin
			wInit_q <= wInit_q | wRegWrite;
		end
	end

	// Request to the core, refreshed every cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			reqValid_q <= 1'b0;
			reqTrap_q  <= 1'b0;
			reqVec_q   <= 8'h00;
			reqLvl_q   <= 4'h0;
		end else begin
			reqValid_q <= winShow;
			reqTrap_q  <= winTrap & winShow;
			reqVec_q   <= winShow ? winVec : 8'h00;
			reqLvl_q   <= winShow ? winLvl : 4'h0;
		end
	end

	// Divide abort and reset request; the reset vector is zero
	always_ff @(posedge clk) begin
		if (rst) begin
			divAbort_q <= 1'b0;
			rstReq_q   <= 1'b0;
			resetPc_q  <= iptr_pkg::RESET_PC;
		end else begin
			divAbort_q <= divByZero;
			rstReq_q   <= anyReset;
			resetPc_q  <= iptr_pkg::RESET_PC;
		end
	end

	// Outputs straight from flops
	assign readdata     = rdData_q;
	assign waitrequest  = waitReq_q;
	assign reqValid     = reqValid_q;
	assign reqIsTrap    = reqTrap_q;
	assign reqVector    = reqVec_q;
	assign reqLevel     = reqLvl_q;
	assign divAbort     = divAbort_q;
	assign coreResetReq = rstReq_q;
	assign resetPc      = resetPc_q;

endmodule
`default_nettype wire

/* iptr_resolver_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module iptr_resolver_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	input wire logic [3:0]  cpuPriorityLevel,
	input wire logic        instrDone,
	input wire logic        divByZero,
	input wire logic        stackFault,
	input wire logic        oscFault,
	input wire logic        watchdogTimeout,
	input wire logic        reqValid,
	input wire logic        reqIsTrap,
	input wire logic [7:0]  reqVector,
	input wire logic [3:0]  reqLevel,
	input wire logic        divAbort,
	input wire logic        coreResetReq,
	input wire logic [23:0] resetPc
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Request, abort, reset and bus outputs checked against their causes
	irq_vector_ok_a: assert property (reqValid && !reqIsTrap |->
		reqLevel inside {[4'h1:4'h7]} && reqVector inside {[8'h08:8'h3D]} &&
		!iptr_pkg::RESERVED_MASK[reqVector - 8'h08]) else $error("bad irq");
	trap_level_ok_a: assert property (reqValid && reqIsTrap |->
		reqLevel[3] && reqVector == {4'h0, reqLevel - 4'h8})
		else $error("bad trap level");
	above_cpu_a: assert property (reqValid |->
		reqLevel > $past(cpuPriorityLevel)) else $error("level too low");
	trap_after_instr_a: assert property (
		$rose(reqValid && reqIsTrap) |-> $past(instrDone))
		else $error("trap before completion");
	idle_quiet_a: assert property (!reqValid |->
		reqVector == 8'h00 && reqLevel == 4'h0 && !reqIsTrap)
		else $error("idle outputs not zero");
	div_abort_a: assert property (divByZero |=> divAbort)
		else $error("divide not aborted");
	wdt_reset_a: assert property (watchdogTimeout |=> coreResetReq)
		else $error("watchdog missed");
	lockout_reset_a: assert property (stackFault && oscFault |=>
		coreResetReq) else $error("lockout missed");
	reset_quiet_a: assert property (coreResetReq |-> !reqValid)
		else $error("request during reset");
	reset_pc_a: assert property (resetPc == 24'h00_0000)
		else $error("reset address not zero");
	bus_answer_a: assert property ((read || write) && waitrequest |=>
		!waitrequest ##1 waitrequest) else $error("bus answer late");
endmodule
bind iptr_resolver iptr_resolver_chk iptr_resolver_chk_inst (
	.clk(clk), .rst(rst), .read(read), .write(write),
	.waitrequest(waitrequest), .cpuPriorityLevel(cpuPriorityLevel),
	.instrDone(instrDone), .divByZero(divByZero), .stackFault(stackFault),
	.oscFault(oscFault), .watchdogTimeout(watchdogTimeout),
	.reqValid(reqValid), .reqIsTrap(reqIsTrap), .reqVector(reqVector),
	.reqLevel(reqLevel), .divAbort(divAbort), .coreResetReq(coreResetReq),
	.resetPc(resetPc)
);
`default_nettype wire

/* iptr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iptr_core_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic ackEn,
	input  wire logic reqValid,
	input  wire logic reqIsTrap,
	output logic      instrDone,
	output logic      trapAck
);
	logic [1:0] cnt_q = 2'h0;
	logic       done_q = 1'h0;
	logic       ack_q = 1'h0;
	// A slow core completes one instruction in four cycles
	always_ff @(posedge clk) begin
		cnt_q <= rst ? 2'h0 : cnt_q + 2'h1;
		done_q <= !rst && (!slow || cnt_q == 2'h3);
	end
	// Acknowledge only when allowed, never two cycles running
	always_ff @(posedge clk) begin
		ack_q <= !rst && ackEn && reqValid && reqIsTrap && !ack_q;
	end
	assign instrDone = done_q;
	assign trapAck = ack_q;
endmodule
`default_nettype wire

/* iptr_resolver_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module iptr_resolver_tb_top;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  address = 8'h00;
	logic        read = 1'h0;
	logic        write = 1'h0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [53:0] irqPending = 54'h0;
	logic [3:0]  cpuPriorityLevel = 4'h0;
	logic [17:0] ev = 18'h0_0000;
	logic        slow = 1'h0;
	logic        ackEn = 1'h0;
	logic [31:0] seed = 32'h0000_0055;
	logic [2:0]  pr [56];
	int          n_mismatch = 0;
	int          compares = 0;
	logic [31:0] readdata;
	logic [7:0]  reqVector;
	logic [3:0]  reqLevel;
	logic [23:0] resetPc;
	logic        waitrequest, reqValid, reqIsTrap, divAbort, coreResetReq;
	logic        instrDone, trapAck;

	// Event bits keep every trap and reset cause on one vector
	iptr_resolver iptr_resolver_inst (
		.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.irqPending(irqPending), .cpuPriorityLevel(cpuPriorityLevel),
		.instrDone(instrDone), .trapAck(trapAck), .divByZero(ev[0]),
		.accOvf31(ev[1]), .guardBitsUnused(ev[2]), .accOvf39(ev[3]),
		.saturationOff(ev[4]), .shiftOverRange(ev[5]), .badTrapVector(ev[6]),
		.addrFault(ev[7]), .stackFault(ev[8]), .oscFault(ev[9]),
		.watchdogTimeout(ev[10]), .opExecute(ev[11]), .opIllegal(ev[12]),
		.opFlushed(ev[13]), .wRegWrite({9'h000, ev[17], 6'h00}),
		.wPtrUse(ev[14]), .wPtrIndex(4'h6), .extResetErr(ev[16:15]),
		.reqValid(reqValid), .reqIsTrap(reqIsTrap), .reqVector(reqVector),
		.reqLevel(reqLevel), .divAbort(divAbort), .coreResetReq(coreResetReq),
		.resetPc(resetPc)
	);
	iptr_core_model iptr_core_model_inst (
		.clk(clk), .rst(rst), .slow(slow), .ackEn(ackEn),
		.reqValid(reqValid), .reqIsTrap(reqIsTrap),
		.instrDone(instrDone), .trapAck(trapAck)
	);

	always #50 clk = !clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Scan downward from the last source so ties fall to the lower number
	function automatic logic [11:0] win(input logic [53:0] p,
			input logic [3:0] cpu);
		logic [11:0] r;
		r = 12'h000;
		for (int i = 53; i >= 0; i--)
			if (p[i] && !iptr_pkg::RESERVED_MASK[i] && pr[i] != 3'h0 &&
					{1'h0, pr[i]} > cpu && {1'h0, pr[i]} >= r[3:0])
				r = {8'(i + 8), 1'h0, pr[i]};
		return r;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hold the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 20);
		if (n >= 20)
			n_mismatch++;
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
		@(posedge clk);
	endtask

	// Fill all priority registers, random when fill is zero
	task automatic prog(input logic [31:0] fill);
		logic [31:0] d, q;
		for (int k = 0; k < 14; k++) begin
			d = fill == 32'h0000_0000 ? rnd() : fill;
			bus(1'h1, 8'(k * 4), d, q);
			bus(1'h0, 8'(k * 4), 32'h0000_0000, q);
			chk(q, d & 32'h0000_7777);
			for (int j = 0; j < 4; j++)
				pr[k * 4 + j] = d[j * 4 +: 3];
		end
	endtask

	task automatic irq(input logic [53:0] p, input logic [3:0] cpu);
		logic [11:0] w;
		w = win(p, cpu);
		@(posedge clk);
		irqPending <= p;
		cpuPriorityLevel <= cpu;
		@(posedge clk);
		#1 chk({reqValid, reqVector, reqLevel}, {|w[3:0], w});
	endtask

	task automatic fire(input logic [17:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 18'h0_0000;
	endtask

	// A zero level means no trap may be showing when the 12-cycle wait runs out
	task automatic trap(input logic [17:0] v, input logic [3:0] lvl,
			input logic ack);
		int n;
		fire(v);
		n = 0;
		while (!(reqValid === 1'h1 && reqLevel === lvl) && n < 12) begin
			@(posedge clk);
			n++;
		end
		chk({reqValid, reqIsTrap, reqVector, reqLevel}, {lvl[3], lvl[3],
			lvl[3] ? {4'h0, lvl - 4'h8} : 8'h00, lvl});
		if (ack) begin
			ackEn <= 1'h1;
			// Long enough to acknowledge two stacked traps one by one
			repeat (16) @(posedge clk);
			ackEn <= 1'h0;
		end
	endtask

	task automatic rc(input logic [17:0] v, input logic e);
		fire(v);
		#1 chk(coreResetReq, e);
	endtask

	// Cut a hang short well after the tests should have ended
	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		logic [31:0] q;
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		bus(1'h0, 8'h60, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		bus(1'h1, 8'h40, 32'hFFFF_FFFF, q);
		bus(1'h1, 8'h44, 32'h003F_FFFF, q);
		prog(32'hBBBB_BBBB);
		irq({54{1'h1}}, 4'h0);
		irq(54'h20_0000_0000_0000, 4'h0);
		irq(54'h00_0020_0000_0000, 4'h0);
		irq({54{1'h1}}, 4'h7);
		irq({54{1'h1}}, 4'h3);
		$display("test fixed order done");
		slow <= 1'h1;
		for (int r = 0; r < 4; r++) begin
			prog(32'h0000_0000);
			for (int t = 0; t < 12; t++)
				irq(54'({rnd(), rnd()} & {rnd(), rnd()}), {1'h0, 3'(rnd())});
		end
		$display("test random done");
		irq(54'h0, 4'h7);
		trap(18'h0_0001, 4'hB, 1'h1);
		trap(18'h0_0006, 4'h0, 1'h1);
		bus(1'h1, 8'h48, 32'h0000_0003, q);
		trap(18'h0_0006, 4'hB, 1'h1);
		trap(18'h0_0008, 4'h0, 1'h1);
		trap(18'h0_0018, 4'hB, 1'h1);
		trap(18'h0_0020, 4'hB, 1'h1);
		trap(18'h0_0040, 4'hC, 1'h1);
		trap(18'h0_0001, 4'hB, 1'h0);
		trap(18'h0_0200, 4'hE, 1'h1);
		$display("test traps done");
		rc(18'h0_0400, 1'h1);
		rc(18'h0_1800, 1'h1);
		rc(18'h0_3800, 1'h0);
		rc(18'h0_4000, 1'h1);
		rc(18'h2_0000, 1'h0);
		rc(18'h0_4000, 1'h0);
		rc(18'h1_8000, 1'h1);
		rc(18'h0_0300, 1'h1);
		trap(18'h0_0000, 4'h0, 1'h0);
		bus(1'h0, 8'h50, 32'h0000_0000, q);
		chk(q, 32'h0000_003F);
		bus(1'h1, 8'h50, 32'h0000_003F, q);
		bus(1'h0, 8'h50, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		$display("test reset causes done");
		final_report();
	end
endmodule
`default_nettype wire
